/* common/pit_pkg.sv */
// Purpose: constants and types for the peripheral interrupt and time base block
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes: flag and enable bits share index positions
package pit_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_PRESCALE_SEL = 8'h00;
   localparam logic [7:0] OFS_TB0_CTRL = 8'h04;
   localparam logic [7:0] OFS_TB1_CTRL = 8'h08;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0c;
   localparam logic [7:0] OFS_IRQ_FLAGS = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;

   // time base control fields
   localparam int TB_ON_BIT = 7;
   localparam int TB_PERIOD_W = 3;
   localparam int TB_CNT_W = 15;
   localparam logic [14:0] TB_CNT_FULL = 15'h7fff;
   localparam logic [2:0] TB_PERIOD_MAX = 3'h7;

   // prescaler source codes and the last count of the quarter-rate divider
   localparam logic [1:0] PSC_SYS = 2'h0;
   localparam logic [1:0] PSC_SYS_DIV4 = 2'h1;
   localparam logic [1:0] DIV4_LAST = 2'h3;

   // flag / enable bit positions; 0..8 are vectored sources in priority order
   localparam int F_CMP0 = 0;
   localparam int F_CMP1 = 1;
   localparam int F_CONV = 2;
   localparam int F_TICK0 = 3;
   localparam int F_TICK1 = 4;
   localparam int F_SHARED = 5;
   localparam int F_SERIAL = 6;
   localparam int F_LOWV = 7;
   localparam int F_EEPROM = 8;
   localparam int F_TIMER1 = 9;
   localparam int F_UART = 10;
   localparam int N_FLAGS = 11;
   localparam int N_VEC = 9;
   localparam int EN_GLOBAL = 11;
   localparam int N_EN = 12;
   localparam int N_UART_EV = 6;

   // status register fields
   localparam int ST_REQ_BIT = 4;
   localparam int ST_UART_LSB = 8;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [N_FLAGS-1:0] FLAGS_RST = 11'h000;
   localparam logic [N_EN-1:0] EN_RST = 12'h000;

   typedef enum logic [3:0] {
      PIT_VEC_CMP0 = 4'h0,
      PIT_VEC_CMP1 = 4'h1,
      PIT_VEC_CONV = 4'h2,
      PIT_VEC_TICK0 = 4'h3,
      PIT_VEC_TICK1 = 4'h4,
      PIT_VEC_SHARED = 4'h5,
      PIT_VEC_SERIAL = 4'h6,
      PIT_VEC_LOWV = 4'h7,
      PIT_VEC_EEPROM = 4'h8
   } pit_vec_t;
endpackage

/* core/pit_core.sv */
// What this block does
// R1: comparator output toggle sets its request flag
// R2: call needs global, source enable, pending, stack free
// R3: comparator service clears its flag
// R4: conversion done sets flag; service clears it
// R5: time base overflow sets flag; service clears
// R6: every service clears the global enable
// R7: prescaler source: sys, sys/4, sub clock
// R8: control bit 7 switches time base on
// R9: timeout is 2^(8+code) prescaler cycles
// R10: unused control bits read as zero
// R11: timer1 or uart request sets shared flag
// R12: shared call needs global, shared, source enables
// R13: shared service clears only the shared flag
// R14: serial byte, address match, timeout set flag
// R15: serial service clears its flag
// R16: six uart conditions raise uart request
// R17: uart flag survives service; software clears it
// R18: uart status events clear only by uart
// R19: low voltage sets flag; service clears it
// R20: eeprom write end sets flag; service clears
// R21: any flag rising wakes the device
// R22: return from interrupt sets global enable
// R23: fixed priority picks one, others stay pending
// Purpose: peripheral interrupt request logic and two periodic time bases
// Assumes: event inputs are one-cycle pulses in the aclk domain
// Notes: register space is an AXI4-Lite slave
//    writes commit one cycle after address and data are both held
//    flags register is plain read/write; a hardware set wins over any clear
//    status register is read only; writes to it answer okay and change nothing
//    a period shorter than the running count wraps the count at once
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
module pit_core (
   input wire logic aclk,
   input wire logic aresetn,
   // register bus write side
   input wire logic [pit_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // register bus read side
   input wire logic [pit_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // prescaler tick and peripheral events
   input wire logic sub_clk_tick,
   input wire logic [1:0] cmp_out,
   input wire logic conv_done,
   input wire logic serial_byte_done,
   input wire logic serial_addr_match,
   input wire logic serial_timeout,
   input wire logic timer1_event,
   input wire logic [pit_pkg::N_UART_EV-1:0] uart_events,
   input wire logic [pit_pkg::N_UART_EV-1:0] uart_status_clr,
   input wire logic low_volt_det,
   input wire logic eeprom_wr_end,
   // cpu vectoring side
   input wire logic stack_full,
   input wire logic irq_ack,
   input wire logic return_from_interrupt,
   output logic irq_req,
   output logic [3:0] irq_vector,
   output logic wake,
   output logic [pit_pkg::N_UART_EV-1:0] uart_status_reg
);

   typedef struct packed {
      // time base setup and counters
      logic [1:0] prescale_src_sel;
      logic [1:0] tick_unit_on;
      logic [1:0][pit_pkg::TB_PERIOD_W-1:0] tick_period_sel;
      logic [1:0][pit_pkg::TB_CNT_W-1:0] tb_cnt;
      logic [1:0] div4;
      // interrupt state
      logic [pit_pkg::N_EN-1:0] en;
      logic [pit_pkg::N_FLAGS-1:0] flags;
      logic [pit_pkg::N_UART_EV-1:0] uart_status;
      // edge detect history, then registered vector, request and wake
      logic [1:0] cmp_prev;
      logic lv_prev;
      pit_pkg::pit_vec_t vec;
      logic req;
      logic wake;
      // bus channel state
      logic [pit_pkg::ADDR_W-1:0] awaddr;
      logic aw_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic w_got;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pit_state_t;

   pit_state_t st_r;
   pit_state_t st_nxt;

   always_comb begin
      logic [pit_pkg::N_FLAGS-1:0] hw_set;
      logic [pit_pkg::N_VEC-1:0] pend;
      logic psc_tick;
      logic [pit_pkg::TB_CNT_W-1:0] limit;
      logic [31:0] wmask;
      logic [31:0] rd;
      logic rd_ok;
      logic contained;
      st_nxt = st_r;
      hw_set = '0;
      pend = '0;
      psc_tick = 1'b0;
      limit = '0;
      wmask = '0;
      rd = '0;
      rd_ok = 1'b1;
      contained = 1'b0;
      st_nxt.wake = 1'b0;

      // quarter-rate enable from the system clock
      st_nxt.div4 = st_r.div4 + 2'h1;
      // R7: prescaler source select
      if (st_r.prescale_src_sel == pit_pkg::PSC_SYS) begin
         psc_tick = 1'b1;
      end else if (st_r.prescale_src_sel == pit_pkg::PSC_SYS_DIV4) begin
         psc_tick = (st_r.div4 == pit_pkg::DIV4_LAST);
      end else begin
         psc_tick = sub_clk_tick;
      end

      // time bases count prescaler ticks up to the selected period
      for (int i = 0; i < 2; i++) begin
         // R9: period of 2^(8+code)
         limit = pit_pkg::TB_CNT_FULL >> (pit_pkg::TB_PERIOD_MAX - st_r.tick_period_sel[i]);
         // R8: unit on / off
         if (!st_r.tick_unit_on[i]) begin
            st_nxt.tb_cnt[i] = '0;
         end else if (psc_tick) begin
            if (st_r.tb_cnt[i] >= limit) begin
               st_nxt.tb_cnt[i] = '0;
               // R5: overflow sets tick flag
               hw_set[pit_pkg::F_TICK0 + i] = 1'b1;
            end else begin
               st_nxt.tb_cnt[i] = st_r.tb_cnt[i] + 15'h0001;
            end
         end
      end

      // R1: comparator toggle detect
      hw_set[pit_pkg::F_CMP0] = cmp_out[0] ^ st_r.cmp_prev[0];
      hw_set[pit_pkg::F_CMP1] = cmp_out[1] ^ st_r.cmp_prev[1];
      st_nxt.cmp_prev = cmp_out;
      // R4: conversion complete
      hw_set[pit_pkg::F_CONV] = conv_done;
      // R14: serial module events
      hw_set[pit_pkg::F_SERIAL] = serial_byte_done | serial_addr_match | serial_timeout;
      // R19: low supply detected
      hw_set[pit_pkg::F_LOWV] = low_volt_det & ~st_r.lv_prev;
      st_nxt.lv_prev = low_volt_det;
      // R20: eeprom write end
      hw_set[pit_pkg::F_EEPROM] = eeprom_wr_end;
      hw_set[pit_pkg::F_TIMER1] = timer1_event;
      // R16: any uart condition
      hw_set[pit_pkg::F_UART] = |uart_events;
      // R11: contained source sets shared flag
      hw_set[pit_pkg::F_SHARED] = timer1_event | (|uart_events);
      // R18: uart status cleared by uart actions only
      st_nxt.uart_status = (st_r.uart_status & ~uart_status_clr) | uart_events;

      // bus write address and data, taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.awaddr = s_axi_awaddr;
         st_nxt.aw_got = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb = s_axi_wstrb;
         st_nxt.w_got = 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.aw_got && st_r.w_got) begin
         for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{st_r.wstrb[b]}};
         end
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = pit_pkg::RESP_OKAY;
         unique case (st_r.awaddr)
            pit_pkg::OFS_PRESCALE_SEL: begin
               if (st_r.wstrb[0]) begin
                  st_nxt.prescale_src_sel = st_r.wdata[1:0];
               end
            end
            pit_pkg::OFS_TB0_CTRL, pit_pkg::OFS_TB1_CTRL: begin
               if (st_r.wstrb[0]) begin
                  if (st_r.awaddr == pit_pkg::OFS_TB0_CTRL) begin
                     st_nxt.tick_unit_on[0] = st_r.wdata[pit_pkg::TB_ON_BIT];
                     st_nxt.tick_period_sel[0] = st_r.wdata[2:0];
                  end else begin
                     st_nxt.tick_unit_on[1] = st_r.wdata[pit_pkg::TB_ON_BIT];
                     st_nxt.tick_period_sel[1] = st_r.wdata[2:0];
                  end
               end
            end
            pit_pkg::OFS_IRQ_ENABLE: begin
               st_nxt.en = (st_r.en & ~wmask[pit_pkg::N_EN-1:0])
                  | (st_r.wdata[pit_pkg::N_EN-1:0] & wmask[pit_pkg::N_EN-1:0]);
            end
            pit_pkg::OFS_IRQ_FLAGS: begin
               // R17: software writes the uart flag
               st_nxt.flags = (st_r.flags & ~wmask[pit_pkg::N_FLAGS-1:0])
                  | (st_r.wdata[pit_pkg::N_FLAGS-1:0] & wmask[pit_pkg::N_FLAGS-1:0]);
            end
            pit_pkg::OFS_IRQ_STATUS: begin
               st_nxt.bresp = pit_pkg::RESP_OKAY;
            end
            default: begin
               st_nxt.bresp = pit_pkg::RESP_SLVERR;
            end
         endcase
      end

      // R22: return from interrupt re-enables
      if (return_from_interrupt) begin
         st_nxt.en[pit_pkg::EN_GLOBAL] = 1'b1;
      end

      // service of the vector offered last cycle
      if (irq_ack && st_r.req) begin
         // R6: service clears global enable
         st_nxt.en[pit_pkg::EN_GLOBAL] = 1'b0;
         unique case (st_r.vec)
            // R3: comparator flag cleared
            pit_pkg::PIT_VEC_CMP0: begin
               st_nxt.flags[pit_pkg::F_CMP0] = 1'b0;
            end
            pit_pkg::PIT_VEC_CMP1: begin
               st_nxt.flags[pit_pkg::F_CMP1] = 1'b0;
            end
            // R4: conversion flag cleared
            pit_pkg::PIT_VEC_CONV: begin
               st_nxt.flags[pit_pkg::F_CONV] = 1'b0;
            end
            // R5: tick flag cleared
            pit_pkg::PIT_VEC_TICK0: begin
               st_nxt.flags[pit_pkg::F_TICK0] = 1'b0;
            end
            pit_pkg::PIT_VEC_TICK1: begin
               st_nxt.flags[pit_pkg::F_TICK1] = 1'b0;
            end
            // R13: contained flags stay set
            pit_pkg::PIT_VEC_SHARED: begin
               st_nxt.flags[pit_pkg::F_SHARED] = 1'b0;
            end
            // R15: serial flag cleared
            pit_pkg::PIT_VEC_SERIAL: begin
               st_nxt.flags[pit_pkg::F_SERIAL] = 1'b0;
            end
            // R19: low voltage flag cleared
            pit_pkg::PIT_VEC_LOWV: begin
               st_nxt.flags[pit_pkg::F_LOWV] = 1'b0;
            end
            // R20: eeprom flag cleared
            pit_pkg::PIT_VEC_EEPROM: begin
               st_nxt.flags[pit_pkg::F_EEPROM] = 1'b0;
            end
            default: begin
            end
         endcase
      end

      // hardware set wins over any clear in the same cycle
      st_nxt.flags = st_nxt.flags | hw_set;

      // R21: wake on any flag rising
      st_nxt.wake = |(st_nxt.flags & ~st_r.flags);

      for (int k = 0; k < pit_pkg::N_VEC; k++) begin
         pend[k] = st_nxt.flags[k] & st_nxt.en[k];
      end
      // R12: shared needs a contained source enabled too
      contained = (st_nxt.flags[pit_pkg::F_TIMER1] & st_nxt.en[pit_pkg::F_TIMER1])
         | (st_nxt.flags[pit_pkg::F_UART] & st_nxt.en[pit_pkg::F_UART]);
      pend[pit_pkg::F_SHARED] = pend[pit_pkg::F_SHARED] & contained;

      // R23: lowest index has highest priority
      st_nxt.vec = pit_pkg::PIT_VEC_CMP0;
      for (int k = pit_pkg::N_VEC - 1; k >= 0; k--) begin
         if (pend[k]) begin
            st_nxt.vec = pit_pkg::pit_vec_t'(4'(k));
         end
      end
      // R2: global, pending, stack not full
      st_nxt.req = st_nxt.en[pit_pkg::EN_GLOBAL] & (|pend) & ~stack_full;

      // bus read
      if (s_axi_rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         unique case (s_axi_araddr)
            // R10: unused bits read zero
            pit_pkg::OFS_PRESCALE_SEL: begin
               rd[1:0] = st_r.prescale_src_sel;
            end
            pit_pkg::OFS_TB0_CTRL: begin
               rd[pit_pkg::TB_ON_BIT] = st_r.tick_unit_on[0];
               rd[2:0] = st_r.tick_period_sel[0];
            end
            pit_pkg::OFS_TB1_CTRL: begin
               rd[pit_pkg::TB_ON_BIT] = st_r.tick_unit_on[1];
               rd[2:0] = st_r.tick_period_sel[1];
            end
            pit_pkg::OFS_IRQ_ENABLE: begin
               rd[pit_pkg::N_EN-1:0] = st_r.en;
            end
            pit_pkg::OFS_IRQ_FLAGS: begin
               rd[pit_pkg::N_FLAGS-1:0] = st_r.flags;
            end
            pit_pkg::OFS_IRQ_STATUS: begin
               rd[3:0] = st_r.vec;
               rd[pit_pkg::ST_REQ_BIT] = st_r.req;
               rd[pit_pkg::ST_UART_LSB +: pit_pkg::N_UART_EV] = st_r.uart_status;
            end
            default: begin
               rd_ok = 1'b0;
            end
         endcase
         st_nxt.rdata = rd;
         st_nxt.rresp = rd_ok ? pit_pkg::RESP_OKAY : pit_pkg::RESP_SLVERR;
         st_nxt.rvalid = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.flags <= pit_pkg::FLAGS_RST;
         st_r.en <= pit_pkg::EN_RST;
         st_r.vec <= pit_pkg::PIT_VEC_CMP0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ready while the slot is free and no response is outstanding
   assign s_axi_awready = ~st_r.aw_got & ~st_r.bvalid;
   assign s_axi_wready = ~st_r.w_got & ~st_r.bvalid;
   assign s_axi_arready = ~st_r.rvalid;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign irq_req = st_r.req;
   assign irq_vector = st_r.vec;
   assign wake = st_r.wake;
   assign uart_status_reg = st_r.uart_status;

endmodule

/* testbench/pit_props.sv */
// Purpose: port checks for the interrupt and time base block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to pit_core
`timescale 1ns/100ps
module pit_props_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [pit_pkg::N_UART_EV-1:0] uart_events,
   input wire logic [pit_pkg::N_UART_EV-1:0] uart_status_clr,
   input wire logic stack_full,
   input wire logic irq_ack,
   input wire logic return_from_interrupt,
   input wire logic irq_req,
   input wire logic [3:0] irq_vector,
   input wire logic [pit_pkg::N_UART_EV-1:0] uart_status_reg
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_ack_drop: assert property (irq_ack && irq_req && !return_from_interrupt |=> !irq_req)
      else $error("request held after service");
   a_stack_block: assert property (stack_full |=> !irq_req)
      else $error("request while stack full");
   a_vec_range: assert property (irq_req |-> irq_vector <= 4'h8)
      else $error("vector out of range");
   a_uart_set: assert property (uart_events != 6'h0 && uart_status_clr == 6'h0
      |=> (uart_status_reg & $past(uart_events)) == $past(uart_events))
      else $error("uart event not recorded");
   a_uart_keep: assert property (uart_status_clr == 6'h0
      |=> (uart_status_reg | $past(uart_status_reg)) == uart_status_reg)
      else $error("uart status lost");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_b_after: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("write response late");
   c_ack: cover property (irq_ack && irq_req);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_uart: cover property (uart_events != 6'h0);
endmodule
bind pit_core pit_props_chk u_props (.*);

/* testbench/pit_cpu_model.sv */
// Purpose: cpu side that services vectored requests
// Assumes: lag gives cycles from request to service
// Notes: service is a one-cycle pulse
`timescale 1ns/100ps
module pit_cpu_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic irq_req,
   input wire logic [3:0] lag,
   output logic irq_ack
);
   logic [3:0] cnt;
   always @(posedge aclk) begin
      irq_ack <= 1'b0;
      if (!aresetn || !irq_req || irq_ack)
         cnt <= 4'h0;
      else if (cnt != lag)
         cnt <= cnt + 4'h1;
      else
         irq_ack <= 1'b1;
   end
endmodule

/* testbench/testbench.sv */
// Purpose: self-checking bench for the interrupt and time base block
// Assumes: cpu model services requests after lag cycles
// Notes: random events from a fixed seed
`timescale 1ns/100ps
module testbench;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
   logic [3:0] s_axi_wstrb, irq_vector, lag;
   logic [1:0] s_axi_bresp, s_axi_rresp, cmp_out, rsp;
   logic sub_clk_tick, conv_done, serial_byte_done, serial_addr_match, serial_timeout;
   logic timer1_event, low_volt_det, eeprom_wr_end, stack_full, irq_ack, return_from_interrupt, irq_req, wake;
   logic [5:0] uart_events, uart_status_clr, uart_status_reg;
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   pit_core dut (.*);
   pit_cpu_model u_cpu (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req), .lag(lag),
      .irq_ack(irq_ack));
   task automatic end_sim;
      if (num_errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, s);
      end
   endtask
   function automatic int exp_period(input logic [1:0] p, input logic [2:0] c);
      return (256 << c) * (p == 2'h0 ? 1 : (p == 2'h1 ? 4 : 8));
   endfunction
   task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {w, w, w};
      {s_axi_arvalid, s_axi_rready} <= {!w, !w};
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) rsp = s_axi_bresp;
         if (s_axi_rvalid && s_axi_rready) {rsp, rdv} = {s_axi_rresp, s_axi_rdata};
         if (s_axi_bvalid || s_axi_rvalid) {s_axi_bready, s_axi_rready} <= 2'h0;
      end while (s_axi_bready || s_axi_rready);
   endtask
   task automatic tb_run(input logic [1:0] p, input logic [2:0] c);
      int t0;
      xfer(1'b1, pit_pkg::OFS_PRESCALE_SEL, 32'(p));
      xfer(1'b1, pit_pkg::OFS_TB0_CTRL, 32'h80 | 32'(c));
      for (int i = 0; i < 3; i++) begin
         @(posedge aclk iff irq_ack);
         chk("tick vector", 32'(irq_vector), 32'h3);
         if (i == 1) t0 = cyc;
         if (i == 2) chk("tick period", 32'(cyc - t0), 32'(exp_period(p, c)));
         return_from_interrupt <= 1'b1;
         @(posedge aclk);
         return_from_interrupt <= 1'b0;
      end
   endtask
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      sub_clk_tick <= (cyc % 8 == 7);
   end
   initial begin
      repeat (60000) @(posedge aclk);
      num_errors++;
      end_sim;
   end
   initial begin
      int k, s, u;
      logic [3:0] ev[6];
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {cmp_out, conv_done, serial_byte_done, serial_addr_match, serial_timeout} = '0;
      {timer1_event, low_volt_det, eeprom_wr_end, stack_full, return_from_interrupt} = '0;
      {uart_events, uart_status_clr, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      lag = 4'hf;
      s_axi_wstrb = 4'hf;
      k = $urandom(32'hff8820a5);
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      xfer(1'b0, pit_pkg::OFS_TB1_CTRL, 32'h0);
      chk("tick1 ctrl reset", rdv, 32'h0);
      xfer(1'b1, pit_pkg::OFS_PRESCALE_SEL, 32'hffffffff);
      xfer(1'b0, pit_pkg::OFS_PRESCALE_SEL, 32'h0);
      chk("prescale sel", rdv, 32'h3);
      xfer(1'b1, pit_pkg::OFS_TB0_CTRL, 32'hffffffff);
      xfer(1'b0, pit_pkg::OFS_TB0_CTRL, 32'h0);
      chk("tick0 ctrl", rdv, 32'h87);
      xfer(1'b0, 8'h40, 32'h0);
      chk("unmapped resp", 32'(rsp), 32'(pit_pkg::RESP_SLVERR));
      chk("unmapped data", rdv, 32'h0);
      xfer(1'b1, pit_pkg::OFS_IRQ_ENABLE, 32'h808);
      tb_run(2'h0, 3'h0);
      tb_run(2'h0, 3'h2);
      tb_run(2'h1, 3'h0);
      tb_run(2'h2 + 2'($urandom_range(1, 0)), 3'h0);
      xfer(1'b1, pit_pkg::OFS_TB0_CTRL, 32'h0);
      xfer(1'b1, pit_pkg::OFS_IRQ_ENABLE, 32'hfff);
      k = $urandom_range(1, 0);
      s = $urandom_range(2, 0);
      u = $urandom_range(63, 1);
      ev = '{4'(k), 4'h2, 4'h5, 4'h6, 4'h7, 4'h8};
      stack_full <= 1'b1;
      @(posedge aclk);
      cmp_out <= 2'(1 << k);
      {conv_done, timer1_event, low_volt_det, eeprom_wr_end} <= 4'hf;
      {serial_byte_done, serial_addr_match, serial_timeout} <= 3'(4 >> s);
      uart_events <= 6'(u);
      @(posedge aclk);
      {conv_done, timer1_event, eeprom_wr_end, serial_byte_done, serial_addr_match} <= 5'h0;
      serial_timeout <= 1'b0;
      uart_events <= 6'h0;
      #1 chk("wake", 32'(wake), 32'h1);
      repeat (8) @(posedge aclk);
      chk("blocked", 32'(irq_req), 32'h0);
      chk("uart status", 32'(uart_status_reg), 32'(u));
      stack_full <= 1'b0;
      foreach (ev[i]) begin
         lag <= 4'($urandom_range(7, 0));
         @(posedge aclk iff irq_ack);
         chk("vector", 32'(irq_vector), 32'(ev[i]));
         return_from_interrupt <= 1'b1;
         @(posedge aclk);
         return_from_interrupt <= 1'b0;
      end
      xfer(1'b0, pit_pkg::OFS_IRQ_FLAGS, 32'h0);
      chk("flags kept", rdv, 32'h600);
      xfer(1'b1, pit_pkg::OFS_IRQ_ENABLE, 32'h820);
      chk("write resp", 32'(rsp), 32'(pit_pkg::RESP_OKAY));
      cmp_out <= 2'h0;
      uart_status_clr <= 6'h3f;
      timer1_event <= 1'b1;
      @(posedge aclk);
      uart_status_clr <= 6'h0;
      timer1_event <= 1'b0;
      repeat (4) @(posedge aclk);
      chk("shared gated", 32'(irq_req), 32'h0);
      chk("uart status clr", 32'(uart_status_reg), 32'h0);
      xfer(1'b0, pit_pkg::OFS_IRQ_FLAGS, 32'h0);
      chk("cmp fall", rdv, 32'h620 | (32'h1 << k));
      xfer(1'b1, pit_pkg::OFS_IRQ_FLAGS, 32'h0);
      xfer(1'b0, pit_pkg::OFS_IRQ_FLAGS, 32'h0);
      chk("uart flag clr", rdv, 32'h0);
      end_sim;
   end
endmodule
